// ---- rtl/switchgear_position_trip_control.sv ----
`timescale 1ns/1ps

// Overview of operation
// - Flag single contact mode when exactly one feedback contact is wired.
// - Supervise move time only in the direction of the wired contact.
// - Close-only: close starts move timer, intermediate, closed plus success on arrival.
// - Close-only: move timeout without closed contact gives faulty, drops intermediate.
// - Close-only: dwell after move time keeps intermediate, then closed.
// - Close-only code: intermediate while closing, else contact 1 closed, else open.
// - No feedback contact wired gives position code 3, faulty.
// - Open-only: open starts move timer, intermediate, open plus success on arrival.
// - Open-only: move timeout without open contact gives faulty, drops intermediate.
// - Open-only: dwell after move time keeps intermediate, then open.
// - Open-only code: intermediate while opening, else contact 1 open, else closed.
// - Three interlocks per direction; any active one blocks that direction.
// - Protection open and auto reclose bypass interlocks; separate block input.
// - OR all assigned trip sources into one trip command.
// - Only the trip manager output trips; unassigned sources do nothing.
// - Trip held for minimum time; latched or non-latched selectable.
// - Latched trip stays after sources drop until acknowledged.
// - Latch clears after sources drop on ack, latch off, or nothing assigned.
// - One external close and one external open request input.
// - Open beats close; close on rising edge, open while level active.
// - Remote commands only with permission remote or local and remote.
// - Command pulses last at most move time, end on new position.
// - Position code 0 intermediate, 1 open, 2 closed, 3 faulty.
// - One command at a time; commands while busy are ignored, except a trip rise reverses a close move.
module switchgear_position_trip_control (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Field side
  input wire sgc_pkg::field_in_s field_in,
  output sgc_pkg::field_out_s field_out
);

  typedef struct packed {
    sgc_pkg::field_in_s s1;
    sgc_pkg::field_in_s s2;
    logic ext_close_q;
    logic ar_q;
    logic trip_q;
    sgc_pkg::ctrl_state_e st;
    logic dir_close;
    logic [31:0] tmr;
    logic faulty;
    logic [31:0] hold;
    logic latched;
    logic [sgc_pkg::CFG_W-1:0] cfg;
    logic [31:0] move_close;
    logic [31:0] move_open;
    logic [31:0] dwell;
    logic [31:0] min_hold;
    logic [sgc_pkg::TRIP_N-1:0] trip_assign;
    logic [sgc_pkg::CMD_W-1:0] cmd;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    sgc_pkg::field_out_s out;
  } state_s;

  state_s r;
  state_s n;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  logic close_w;
  logic open_w;
  logic at_closed;
  logic at_open;
  logic src_any;
  logic ack;
  logic trip_en;
  logic trip_rise;
  logic remote_ok;
  logic local_ok;
  logic open_req;
  logic close_req;
  logic open_go;
  logic close_go;
  logic reached;
  logic sup;
  logic moving_sup;
  logic [31:0] wval;
  logic [31:0] rval;
  logic [1:0] code;

  always_comb begin
    n = r;
    wval = 32'h0000_0000;
    rval = 32'h0000_0000;
    // Two-stage synchroniser for all field pins
    n.s1 = field_in;
    n.s2 = r.s1;
    n.cmd = '0;
    n.out.command_exec_success = 1'b0;
    close_w = r.cfg[sgc_pkg::CFG_CLOSE_WIRED];
    open_w = r.cfg[sgc_pkg::CFG_OPEN_WIRED];

    at_closed = close_w ? (r.s2.closed_contact & ~(open_w & r.s2.open_contact))
                        : (open_w & ~r.s2.open_contact);
    at_open = open_w ? (r.s2.open_contact & ~(close_w & r.s2.closed_contact))
                     : (close_w & ~r.s2.closed_contact);

    src_any = |(r.s2.trip_source & r.trip_assign);
    ack = r.s2.trip_acknowledge | r.cmd[sgc_pkg::CMD_TRIP_ACK];
    if (src_any) begin
      n.hold = r.min_hold;
    end else if (r.hold != 32'h0000_0000) begin
      n.hold = r.hold - 32'h0000_0001;
    end
    if (src_any && r.cfg[sgc_pkg::CFG_LATCH]) begin
      n.latched = 1'b1;
    end else if (!src_any && (ack || !r.cfg[sgc_pkg::CFG_LATCH] ||
                              r.trip_assign == '0)) begin
      n.latched = 1'b0;
    end
    trip_en = (src_any | (r.hold != 32'h0000_0000) | r.latched) & ~r.s2.protection_block;
    n.trip_q = trip_en;
    trip_rise = trip_en & ~r.trip_q;
    n.out.trip_command = trip_en;

    remote_ok = (r.cfg[sgc_pkg::CFG_PERM_LO +: 2] == sgc_pkg::PERM_REMOTE) ||
                (r.cfg[sgc_pkg::CFG_PERM_LO +: 2] == sgc_pkg::PERM_BOTH);
    local_ok = (r.cfg[sgc_pkg::CFG_PERM_LO +: 2] == sgc_pkg::PERM_LOCAL) ||
               (r.cfg[sgc_pkg::CFG_PERM_LO +: 2] == sgc_pkg::PERM_BOTH);
    n.ext_close_q = r.s2.external_close_request;
    n.ar_q = r.s2.auto_reclose;
    open_req = (remote_ok & (r.cmd[sgc_pkg::CMD_REMOTE_OPEN] | r.s2.external_open_request)) |
               (local_ok & r.cmd[sgc_pkg::CMD_LOCAL_OPEN]);
    close_req = (remote_ok & (r.cmd[sgc_pkg::CMD_REMOTE_CLOSE] |
                              (r.s2.external_close_request & ~r.ext_close_q))) |
                (local_ok & r.cmd[sgc_pkg::CMD_LOCAL_CLOSE]);
    open_go = (open_req & ~(|r.s2.open_interlock)) | trip_rise;
    close_go = ~open_req & ~trip_en &
               ((close_req & ~(|r.s2.close_interlock)) | (r.s2.auto_reclose & ~r.ar_q));

    reached = r.dir_close ? at_closed : at_open;
    sup = r.dir_close ? close_w : open_w;
    if (r.faulty && reached) begin
      n.faulty = 1'b0;
    end

    case (r.st)
      sgc_pkg::ST_IDLE: begin
        if (open_go && !at_open) begin
          n.st = sgc_pkg::ST_MOVE;
          n.dir_close = 1'b0;
          n.tmr = r.move_open;
          n.faulty = 1'b0;
        end else if (close_go && !at_closed) begin
          n.st = sgc_pkg::ST_MOVE;
          n.dir_close = 1'b1;
          n.tmr = r.move_close;
          n.faulty = 1'b0;
        end
      end
      sgc_pkg::ST_MOVE: begin
        n.tmr = r.tmr - 32'h0000_0001;
        if (r.dir_close && trip_rise && !at_open) begin
          n.dir_close = 1'b0;
          n.tmr = r.move_open;
        end else if (reached && r.dwell == 32'h0000_0000) begin
          n.st = sgc_pkg::ST_IDLE;
          n.out.command_exec_success = 1'b1;
        end else if (r.tmr <= 32'h0000_0001) begin
          if (reached) begin
            n.st = sgc_pkg::ST_DWELL;
            n.tmr = r.dwell;
          end else begin
            n.st = sgc_pkg::ST_IDLE;
            n.faulty = sup;
          end
        end
      end
      sgc_pkg::ST_DWELL: begin
        n.tmr = r.tmr - 32'h0000_0001;
        if (r.tmr <= 32'h0000_0001) begin
          n.st = sgc_pkg::ST_IDLE;
          n.out.command_exec_success = reached;
          n.faulty = sup & ~reached;
        end
      end
      default: begin
        n.st = sgc_pkg::ST_IDLE;
      end
    endcase

    n.out.close_pulse = (n.st == sgc_pkg::ST_MOVE) & n.dir_close &
                        ~(n.st == r.st && at_closed);
    n.out.open_pulse = (n.st == sgc_pkg::ST_MOVE) & ~n.dir_close &
                       ~(n.st == r.st && at_open);

    // Code follows the next state, so success and end position rise together
    moving_sup = (n.st != sgc_pkg::ST_IDLE) & sup;
    if (!close_w && !open_w) begin
      code = sgc_pkg::POS_FAULTY;
    end else if (moving_sup) begin
      code = sgc_pkg::POS_INTERMEDIATE;
    end else if (n.faulty && !reached) begin
      code = sgc_pkg::POS_FAULTY;
    end else if (at_closed) begin
      code = sgc_pkg::POS_CLOSED;
    end else if (at_open) begin
      code = sgc_pkg::POS_OPEN;
    end else begin
      code = sgc_pkg::POS_FAULTY;
    end
    n.out.position_code = code;
    n.out.position_intermediate = code == sgc_pkg::POS_INTERMEDIATE;
    n.out.position_open = code == sgc_pkg::POS_OPEN;
    n.out.position_closed = code == sgc_pkg::POS_CLOSED;
    n.out.position_faulty = code == sgc_pkg::POS_FAULTY;
    n.out.single_contact_flag = close_w ^ open_w;

    // AXI write channel
    if (s_axi_awvalid && !r.aw_held) begin
      n.aw_held = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_held) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = sgc_pkg::RESP_OKAY;
      case (r.awaddr)
        sgc_pkg::REG_CONFIG: begin
          wval = merge({27'h0, r.cfg}, r.wdata, r.wstrb);
          n.cfg = wval[sgc_pkg::CFG_W-1:0];
        end
        sgc_pkg::REG_MOVE_CLOSE: n.move_close = merge(r.move_close, r.wdata, r.wstrb);
        sgc_pkg::REG_MOVE_OPEN: n.move_open = merge(r.move_open, r.wdata, r.wstrb);
        sgc_pkg::REG_DWELL: n.dwell = merge(r.dwell, r.wdata, r.wstrb);
        sgc_pkg::REG_MIN_HOLD: n.min_hold = merge(r.min_hold, r.wdata, r.wstrb);
        sgc_pkg::REG_TRIP_ASSIGN: begin
          wval = merge({24'h0, r.trip_assign}, r.wdata, r.wstrb);
          n.trip_assign = wval[sgc_pkg::TRIP_N-1:0];
        end
        sgc_pkg::REG_COMMAND: begin
          wval = merge(32'h0000_0000, r.wdata, r.wstrb);
          n.cmd = wval[sgc_pkg::CMD_W-1:0];
        end
        sgc_pkg::REG_STATUS: n.bresp = sgc_pkg::RESP_OKAY;
        default: n.bresp = sgc_pkg::RESP_SLVERR;
      endcase
    end

    // AXI read channel
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = sgc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        sgc_pkg::REG_CONFIG: rval = {27'h0, r.cfg};
        sgc_pkg::REG_MOVE_CLOSE: rval = r.move_close;
        sgc_pkg::REG_MOVE_OPEN: rval = r.move_open;
        sgc_pkg::REG_DWELL: rval = r.dwell;
        sgc_pkg::REG_MIN_HOLD: rval = r.min_hold;
        sgc_pkg::REG_TRIP_ASSIGN: rval = {24'h0, r.trip_assign};
        sgc_pkg::REG_COMMAND: rval = 32'h0000_0000;
        sgc_pkg::REG_STATUS: rval = {17'h0, r.latched, r.faulty, r.st, r.out};
        default: n.rresp = sgc_pkg::RESP_SLVERR;
      endcase
      n.rdata = rval;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= sgc_pkg::ST_IDLE;
      r.cfg <= sgc_pkg::CFG_RESET;
      r.move_close <= sgc_pkg::MOVE_CLOSE_RESET;
      r.move_open <= sgc_pkg::MOVE_OPEN_RESET;
      r.dwell <= sgc_pkg::DWELL_RESET;
      r.min_hold <= sgc_pkg::MIN_HOLD_RESET;
      r.trip_assign <= sgc_pkg::TRIP_ASSIGN_RESET;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready = ~r.aw_held;
  assign s_axi_wready = ~r.w_held;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = ~r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign field_out = r.out;

endmodule : switchgear_position_trip_control

// ---- inc/sgc_pkg.sv ----
package sgc_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_MOVE_CLOSE = 8'h04;
  localparam logic [7:0] REG_MOVE_OPEN = 8'h08;
  localparam logic [7:0] REG_DWELL = 8'h0C;
  localparam logic [7:0] REG_MIN_HOLD = 8'h10;
  localparam logic [7:0] REG_TRIP_ASSIGN = 8'h14;
  localparam logic [7:0] REG_COMMAND = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  // Config fields
  localparam int CFG_CLOSE_WIRED = 0;
  localparam int CFG_OPEN_WIRED = 1;
  localparam int CFG_PERM_LO = 2;
  localparam int CFG_LATCH = 4;
  localparam int CFG_W = 5;
  localparam logic [4:0] CFG_RESET = 5'h01;

  // Command fields, write one to act
  localparam int CMD_REMOTE_CLOSE = 0;
  localparam int CMD_REMOTE_OPEN = 1;
  localparam int CMD_LOCAL_CLOSE = 2;
  localparam int CMD_LOCAL_OPEN = 3;
  localparam int CMD_TRIP_ACK = 4;
  localparam int CMD_W = 5;

  // Switching permission codes
  localparam logic [1:0] PERM_NONE = 2'h0;
  localparam logic [1:0] PERM_LOCAL = 2'h1;
  localparam logic [1:0] PERM_REMOTE = 2'h2;
  localparam logic [1:0] PERM_BOTH = 2'h3;

  // Position codes
  localparam logic [1:0] POS_INTERMEDIATE = 2'h0;
  localparam logic [1:0] POS_OPEN = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] POS_FAULTY = 2'h3;

  // Timer reset values in clock ticks, then trip assignment reset mask
  localparam logic [31:0] MOVE_CLOSE_RESET = 32'h0000_0100;
  localparam logic [31:0] MOVE_OPEN_RESET = 32'h0000_0100;
  localparam logic [31:0] DWELL_RESET = 32'h0000_0000;
  localparam logic [31:0] MIN_HOLD_RESET = 32'h0000_0010;
  localparam logic [7:0] TRIP_ASSIGN_RESET = 8'h00;

  localparam int TRIP_N = 8;
  localparam int ILK_N = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_DWELL} ctrl_state_e;

  typedef struct packed {
    logic closed_contact;
    logic open_contact;
    logic [ILK_N-1:0] close_interlock;
    logic [ILK_N-1:0] open_interlock;
    logic protection_block;
    logic [TRIP_N-1:0] trip_source;
    logic trip_acknowledge;
    logic external_close_request;
    logic external_open_request;
    logic auto_reclose;
  } field_in_s;

  typedef struct packed {
    logic close_pulse;
    logic open_pulse;
    logic trip_command;
    logic [1:0] position_code;
    logic position_open;
    logic position_closed;
    logic position_intermediate;
    logic position_faulty;
    logic single_contact_flag;
    logic command_exec_success;
  } field_out_s;

endpackage : sgc_pkg

// ---- bench/sgc_field_model.sv ----
`timescale 1ns/1ps
module sgc_field_model #(parameter int DLY = 3) (
  // Clock
  input wire logic aclk,
  // Command relays
  input wire logic close_pulse,
  input wire logic open_pulse,
  // Bench controls: stuck drive, hand operation 1 open 2 closed
  input wire logic jam,
  input wire logic [1:0] hand,
  // Auxiliary contacts
  output logic closed_contact,
  output logic open_contact
);
  int cnt = 0;
  logic is_closed = 1'b0;
  always @(posedge aclk) begin
    if (hand != 2'h0) begin
      is_closed <= hand[1];
      cnt <= 0;
    end else if (!jam && (close_pulse ^ open_pulse) && (close_pulse != is_closed)) begin
      cnt <= cnt + 1;
      if (cnt == DLY) begin
        is_closed <= close_pulse;
      end
    end else begin
      cnt <= 0;
    end
  end
  assign closed_contact = is_closed;
  assign open_contact = !is_closed;
endmodule : sgc_field_model

// ---- bench/sgc_chk.sv ----
`timescale 1ns/1ps
module sgc_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Field side
  input wire sgc_pkg::field_in_s field_in,
  input wire sgc_pkg::field_out_s field_out
);
  localparam int MAX_PULSE = 258;
  bit rst_ok;
  logic [8:0] pulse_cnt;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!rst_ok);
  // Outputs follow state one edge after release
  always_ff @(posedge aclk) begin
    rst_ok <= aresetn;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !(field_out.close_pulse || field_out.open_pulse)) begin
      pulse_cnt <= '0;
    end else if (pulse_cnt != 9'h1FF) begin
      pulse_cnt <= pulse_cnt + 9'h001;
    end
  end
  sequence s_blocked;
    field_in.protection_block [*5];
  endsequence
  sequence s_done;
    field_out.command_exec_success ##1 !field_out.command_exec_success;
  endsequence
  property p_decode;
    field_out.position_open == (field_out.position_code == sgc_pkg::POS_OPEN) &&
    field_out.position_closed == (field_out.position_code == sgc_pkg::POS_CLOSED) &&
    field_out.position_faulty == (field_out.position_code == sgc_pkg::POS_FAULTY) &&
    field_out.position_intermediate == (field_out.position_code == sgc_pkg::POS_INTERMEDIATE);
  endproperty
  a_code_decode: assert property (p_decode)
    else $error("position flags disagree with code");
  a_one_command: assert property (!(field_out.close_pulse && field_out.open_pulse))
    else $error("close and open pulses together");
  a_block_trip: assert property (s_blocked |-> !field_out.trip_command)
    else $error("trip issued while blocked");
  a_success_once: assert property (field_out.command_exec_success |-> s_done)
    else $error("success longer than one cycle");
  a_success_end: assert property (field_out.command_exec_success |->
    (field_out.position_open || field_out.position_closed))
    else $error("success without end position");
  a_success_quiet: assert property (field_out.command_exec_success |->
    !field_out.close_pulse && !field_out.open_pulse)
    else $error("pulse still on at success");
  a_faulty_quiet: assert property (field_out.position_faulty |->
    !field_out.close_pulse && !field_out.open_pulse)
    else $error("pulse still on when faulty");
  a_pulse_bound: assert property (pulse_cnt <= MAX_PULSE)
    else $error("command pulse too long");
  c_done: cover property (s_done);
endmodule : sgc_chk

// ---- bench/tb_switchgear_position_trip_control.sv ----
`timescale 1ns/1ps
module tb_switchgear_position_trip_control;
  localparam int SUCC = 0, FLAG = 1, FAULTY = 2, INTERM = 3, TRIP = 8, OPUL = 9, CPUL = 10;
  logic aclk, aresetn, jam, m_closed, m_open;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r, hand;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  sgc_pkg::field_in_s fin, fin_w;
  sgc_pkg::field_out_s fout;
  logic [10:0] fo;
  int failures = 0, compares = 0, cp_n = 0, tr_n = 0, n;
  assign fo = fout;
  always_comb begin
    fin_w = fin;
    fin_w.closed_contact = m_closed;
    fin_w.open_contact = m_open;
  end
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (fout.close_pulse === 1'b1) cp_n++;
    if (fout.trip_command === 1'b1) tr_n++;
  end
  switchgear_position_trip_control i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .field_in(fin_w), .field_out(fout));
  sgc_field_model i_sw (.aclk(aclk), .close_pulse(fout.close_pulse),
    .open_pulse(fout.open_pulse), .jam(jam), .hand(hand),
    .closed_contact(m_closed), .open_contact(m_open));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // Ready is sampled mid-cycle; it only changes after rising edges
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    int k;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100 && !b; k++) begin
      @(negedge aclk);
      aw = aw && !awready;
      w = w && !wready;
      b = bvalid;
      @(posedge aclk);
      awvalid <= aw;
      wvalid <= w;
    end
    bready <= 1'b0;
    chk(b, 1'b1);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    logic ap, g;
    int k;
    ap = 1'b1;
    g = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100 && !g; k++) begin
      @(negedge aclk);
      ap = ap && !arready;
      g = rvalid;
      v = rdata;
      e = rresp;
      @(posedge aclk);
      arvalid <= ap;
    end
    rready <= 1'b0;
    chk(g, 1'b1);
  endtask : axi_rd
  task automatic wait_out(input int b, input logic v);
    int k;
    k = 0;
    do begin
      @(negedge aclk);
      k++;
    end while (fo[b] !== v && k < 300);
    chk(fo[b], v);
  endtask : wait_out
  task automatic code_is(input logic [1:0] exp);
    repeat (4) @(negedge aclk);
    chk(fout.position_code, exp);
  endtask : code_is
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_of_test();
  end
  initial begin
    {fin, jam, hand, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, aresetn} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(sgc_pkg::REG_CONFIG, d, r);
    chk(d, 32'h0000_0001);
    axi_rd(sgc_pkg::REG_MOVE_CLOSE, d, r);
    chk(d, 32'h0000_0100);
    axi_rd(8'h20, d, r);
    chk({r, d}, {sgc_pkg::RESP_SLVERR, 32'h0});
    $display("test registers done");
    axi_wr(sgc_pkg::REG_MOVE_CLOSE, 32'h8);
    axi_wr(sgc_pkg::REG_MOVE_OPEN, 32'h8);
    axi_wr(sgc_pkg::REG_MIN_HOLD, 32'h6);
    axi_wr(sgc_pkg::REG_TRIP_ASSIGN, 32'h1);
    axi_wr(sgc_pkg::REG_CONFIG, 32'h0D);
    wait_out(FLAG, 1'b1);
    code_is(sgc_pkg::POS_OPEN);
    @(posedge aclk);
    fin.close_interlock <= 3'h4;
    n = cp_n;
    axi_wr(sgc_pkg::REG_COMMAND, 32'h1);
    repeat (12) @(negedge aclk);
    chk(cp_n, n);
    @(posedge aclk);
    fin.close_interlock <= 3'h0;
    axi_wr(sgc_pkg::REG_COMMAND, 32'h1);
    wait_out(CPUL, 1'b1);
    wait_out(INTERM, 1'b1);
    wait_out(SUCC, 1'b1);
    code_is(sgc_pkg::POS_CLOSED);
    wait_out(CPUL, 1'b0);
    n = cp_n;
    axi_wr(sgc_pkg::REG_COMMAND, 32'h1);
    repeat (12) @(negedge aclk);
    chk(cp_n, n);
    $display("test close done");
    n = tr_n;
    @(posedge aclk);
    fin.protection_block <= 1'b1;
    fin.trip_source <= 8'h01;
    repeat (8) @(negedge aclk);
    wait_out(TRIP, 1'b0);
    @(posedge aclk);
    fin.trip_source <= 8'h00;
    repeat (12) @(negedge aclk);
    chk(tr_n, n);
    @(posedge aclk);
    fin.trip_source <= 8'h02;
    fin.protection_block <= 1'b0;
    repeat (12) @(negedge aclk);
    chk(tr_n, n);
    @(posedge aclk);
    fin.trip_source <= 8'h01;
    @(posedge aclk);
    fin.trip_source <= 8'h00;
    wait_out(TRIP, 1'b1);
    repeat (4) @(negedge aclk);
    wait_out(TRIP, 1'b1);
    wait_out(TRIP, 1'b0);
    axi_wr(sgc_pkg::REG_CONFIG, 32'h1D);
    fin.trip_source <= 8'h01;
    @(posedge aclk);
    fin.trip_source <= 8'h00;
    wait_out(TRIP, 1'b1);
    repeat (30) @(negedge aclk);
    wait_out(TRIP, 1'b1);
    axi_wr(sgc_pkg::REG_COMMAND, 32'h10);
    wait_out(TRIP, 1'b0);
    $display("test trip done");
    @(posedge aclk);
    hand <= 2'h2;
    @(posedge aclk);
    hand <= 2'h0;
    axi_wr(sgc_pkg::REG_CONFIG, 32'h0E);
    code_is(sgc_pkg::POS_CLOSED);
    @(posedge aclk);
    fin.external_open_request <= 1'b1;
    wait_out(OPUL, 1'b1);
    wait_out(SUCC, 1'b1);
    code_is(sgc_pkg::POS_OPEN);
    @(posedge aclk);
    fin.external_close_request <= 1'b1;
    n = cp_n;
    repeat (12) @(negedge aclk);
    @(posedge aclk);
    fin.external_open_request <= 1'b0;
    repeat (12) @(negedge aclk);
    chk(cp_n, n);
    @(posedge aclk);
    fin.external_close_request <= 1'b0;
    repeat (4) @(negedge aclk);
    @(posedge aclk);
    fin.external_close_request <= 1'b1;
    wait_out(CPUL, 1'b1);
    wait_out(SUCC, 1'b1);
    axi_wr(sgc_pkg::REG_CONFIG, 32'h06);
    axi_wr(sgc_pkg::REG_COMMAND, 32'h2);
    code_is(sgc_pkg::POS_CLOSED);
    axi_wr(sgc_pkg::REG_COMMAND, 32'h8);
    wait_out(OPUL, 1'b1);
    axi_wr(sgc_pkg::REG_COMMAND, 32'h4);
    wait_out(SUCC, 1'b1);
    code_is(sgc_pkg::POS_OPEN);
    @(posedge aclk);
    hand <= 2'h2;
    @(posedge aclk);
    hand <= 2'h0;
    axi_wr(sgc_pkg::REG_DWELL, 32'h4);
    axi_wr(sgc_pkg::REG_COMMAND, 32'h8);
    wait_out(OPUL, 1'b0);
    chk(fo[INTERM], 1'b1);
    wait_out(SUCC, 1'b1);
    code_is(sgc_pkg::POS_OPEN);
    @(posedge aclk);
    fin.external_open_request <= 1'b0;
    jam <= 1'b1;
    $display("test open done");
    axi_wr(sgc_pkg::REG_CONFIG, 32'h0D);
    axi_wr(sgc_pkg::REG_COMMAND, 32'h1);
    wait_out(FAULTY, 1'b1);
    wait_out(INTERM, 1'b0);
    wait_out(CPUL, 1'b0);
    axi_wr(sgc_pkg::REG_CONFIG, 32'h0C);
    code_is(sgc_pkg::POS_FAULTY);
    $display("test fault done");
    end_of_test();
  end
endmodule : tb_switchgear_position_trip_control
bind switchgear_position_trip_control sgc_chk i_chk (.aclk(aclk), .aresetn(aresetn),
  .field_in(field_in), .field_out(field_out));
